// ---- shared/pfc_pkg.sv ----
// Package with register map, field codes and carrier types for pin three and frame trigger
package pfc_pkg;
	localparam logic [7:0] PFC_OFS_PIN3_CTL = 8'h13;
	localparam logic [7:0] PFC_OFS_RSVD_LO = 8'h14;
	localparam logic [7:0] PFC_OFS_RSVD_HI = 8'h17;
	localparam logic [7:0] PFC_OFS_FT_CTL = 8'h18;
	localparam logic [7:0] PFC_OFS_HIGH_1 = 8'h19;
	localparam logic [7:0] PFC_OFS_HIGH_0 = 8'h1A;
	localparam logic [7:0] PFC_OFS_LOW_1 = 8'h1B;
	localparam logic [7:0] PFC_OFS_LOW_0 = 8'h1C;
	localparam logic [7:0] PFC_RST_REG = 8'h00;
	localparam logic [15:0] PFC_RST_COUNT = 16'h0000;
	localparam int PFC_BIT_ONE_SHOT = 3;
	// Source codes
	localparam logic [2:0] PFC_SRC_PORT0 = 3'h0;
	localparam logic [2:0] PFC_SRC_PORT1 = 3'h1;
	localparam logic [2:0] PFC_SRC_STATUS = 3'h4;
	// Select codes for a receive port
	localparam logic [2:0] PFC_SEL_LOCK = 3'h4;
	localparam logic [2:0] PFC_SEL_PASS = 3'h5;
	// Select codes for device status
	localparam logic [2:0] PFC_SEL_LOCAL = 3'h0;
	localparam logic [2:0] PFC_SEL_OR_LOCK = 3'h1;
	localparam logic [2:0] PFC_SEL_AND_LOCK = 3'h2;
	localparam logic [2:0] PFC_SEL_AND_PASS = 3'h3;
	localparam logic [2:0] PFC_SEL_TRIGGER = 3'h4;
	// Frame trigger source modes
	localparam logic [3:0] PFC_MODE_BC0 = 4'h0;
	localparam logic [3:0] PFC_MODE_BC1 = 4'h1;
	localparam logic [3:0] PFC_MODE_REF = 4'h4;
	localparam logic [3:0] PFC_MODE_EXT0 = 4'h8;
	localparam logic [3:0] PFC_MODE_EXT3 = 4'hB;

	typedef struct packed {
		logic [2:0] signal_select;
		logic [2:0] source_select;
		logic local_value;
		logic drive_enable;
	} pfc_pin_ctl_s;

	typedef struct packed {
		logic [3:0] source_mode;
		logic one_shot;
		logic initial_level;
		logic duty_mode;
		logic continuous_enable;
	} pfc_ft_ctl_s;

	typedef struct packed {
		logic [1:0] lock;
		logic [1:0] pass;
		logic [1:0] enabled;
		logic [3:0] remote_pins_0;
		logic [3:0] remote_pins_1;
	} pfc_port_status_s;

	typedef enum logic [1:0] {
		PFC_FT_IDLE,
		PFC_FT_RUN,
		PFC_FT_SHOT_HIGH,
		PFC_FT_SHOT_LOW
	} pfc_ft_state_e;
endpackage

// ---- src/pfc_pin_trigger.sv ----
// Pin three output selection and frame trigger source control
//
// Operation
// - 3-bit source: port0, port1, device status
// - Port select: remote pins, lock, pass
// - Status select 000 drives local value
// - Status 001 OR lock, 010/011 AND
// - Status 100 drives frame trigger
// - Drive only when enabled; value bit
// - Modes 0000/0001 use back-channel frame clock
// - One mode uses 25 MHz reference
// - Modes 1000-1011 take external pin 0-3
// - Other mode codes reserved, no trigger
// - Writing one-shot bit makes one pulse when generator idle; ignored during continuous run
// - No new pulse before duration ends
// - One-shot bit self clears, reads zero
// - Continuous generation only while enabled
// - Generation starts at initial level bit
// - Phase lasts programmed count plus one
`timescale 1ns/1ps
module pfc_pin_trigger (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Register access
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_read,
	output logic [7:0] reg_rdata_ff,
	// Receive port state and trigger sources
	input wire pfc_pkg::pfc_port_status_s port_status,
	input wire logic [1:0] bc_frame_tick,
	input wire logic ref_tick,
	input wire logic [3:0] general_pin_in,
	// Pin three and trigger outputs
	output logic general_pin_three_out_ff,
	output logic general_pin_three_oe_ff,
	output logic frame_trigger_ff
);
	import pfc_pkg::*;

	pfc_pin_ctl_s pin_ctl_ff, nxt_pin_ctl;
	pfc_ft_ctl_s ft_ctl_ff, nxt_ft_ctl;
	logic [15:0] high_count_ff, nxt_high_count;
	logic [15:0] low_count_ff, nxt_low_count;
	logic [7:0] nxt_reg_rdata;
	logic shot_req;

	// Register writes and reads
	always_comb begin
		nxt_pin_ctl = pin_ctl_ff;
		nxt_ft_ctl = ft_ctl_ff;
		nxt_ft_ctl.one_shot = 1'b0;
		nxt_high_count = high_count_ff;
		nxt_low_count = low_count_ff;
		nxt_reg_rdata = reg_rdata_ff;
		shot_req = 1'b0;
		if (reg_write) begin
			if (reg_addr == PFC_OFS_PIN3_CTL) begin
				nxt_pin_ctl = pfc_pin_ctl_s'(reg_wdata);
			end else if (reg_addr == PFC_OFS_FT_CTL) begin
				nxt_ft_ctl = pfc_ft_ctl_s'(reg_wdata);
				nxt_ft_ctl.one_shot = 1'b0;
				shot_req = reg_wdata[PFC_BIT_ONE_SHOT];
			end else if (reg_addr == PFC_OFS_HIGH_1) begin
				nxt_high_count[15:8] = reg_wdata;
			end else if (reg_addr == PFC_OFS_HIGH_0) begin
				nxt_high_count[7:0] = reg_wdata;
			end else if (reg_addr == PFC_OFS_LOW_1) begin
				nxt_low_count[15:8] = reg_wdata;
			end else if (reg_addr == PFC_OFS_LOW_0) begin
				nxt_low_count[7:0] = reg_wdata;
			end
		end
		if (reg_read) begin
			if (reg_addr == PFC_OFS_PIN3_CTL) begin
				nxt_reg_rdata = pin_ctl_ff;
			end else if (reg_addr == PFC_OFS_FT_CTL) begin
				nxt_reg_rdata = ft_ctl_ff;
			end else if (reg_addr == PFC_OFS_HIGH_1) begin
				nxt_reg_rdata = high_count_ff[15:8];
			end else if (reg_addr == PFC_OFS_HIGH_0) begin
				nxt_reg_rdata = high_count_ff[7:0];
			end else if (reg_addr == PFC_OFS_LOW_1) begin
				nxt_reg_rdata = low_count_ff[15:8];
			end else if (reg_addr == PFC_OFS_LOW_0) begin
				nxt_reg_rdata = low_count_ff[7:0];
			end else begin
				nxt_reg_rdata = PFC_RST_REG;
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pin_ctl_ff <= pfc_pin_ctl_s'(PFC_RST_REG);
			ft_ctl_ff <= pfc_ft_ctl_s'(PFC_RST_REG);
			high_count_ff <= PFC_RST_COUNT;
			low_count_ff <= PFC_RST_COUNT;
			reg_rdata_ff <= PFC_RST_REG;
		end else begin
			pin_ctl_ff <= nxt_pin_ctl;
			ft_ctl_ff <= nxt_ft_ctl;
			high_count_ff <= nxt_high_count;
			low_count_ff <= nxt_low_count;
			reg_rdata_ff <= nxt_reg_rdata;
		end
	end

	// Frame trigger generator
	pfc_ft_state_e state_ff, nxt_state;
	logic [15:0] cnt_ff, nxt_cnt;
	logic level_ff, nxt_level;
	logic nxt_trigger;
	logic gen_tick;
	logic [15:0] limit;
	logic ext_mode;

	always_comb begin
		gen_tick = 1'b0;
		ext_mode = 1'b0;
		if (ft_ctl_ff.source_mode == PFC_MODE_BC0) begin
			gen_tick = bc_frame_tick[0];
		end else if (ft_ctl_ff.source_mode == PFC_MODE_BC1) begin
			gen_tick = bc_frame_tick[1];
		end else if (ft_ctl_ff.source_mode == PFC_MODE_REF) begin
			gen_tick = ref_tick;
		end else if (ft_ctl_ff.source_mode >= PFC_MODE_EXT0
				&& ft_ctl_ff.source_mode <= PFC_MODE_EXT3) begin
			ext_mode = 1'b1;
		end
		limit = level_ff ? high_count_ff : low_count_ff;
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_level = level_ff;
		case (state_ff)
			PFC_FT_IDLE: begin
				nxt_level = ft_ctl_ff.initial_level;
				nxt_cnt = PFC_RST_COUNT;
				if (shot_req) begin
					nxt_state = PFC_FT_SHOT_HIGH;
					nxt_level = 1'b1;
				end else if (ft_ctl_ff.continuous_enable) begin
					nxt_state = PFC_FT_RUN;
					nxt_level = ft_ctl_ff.initial_level;
				end
			end
			PFC_FT_RUN: begin
				if (!ft_ctl_ff.continuous_enable) begin
					nxt_state = PFC_FT_IDLE;
				end else if (gen_tick) begin
					if (cnt_ff == limit) begin
						nxt_cnt = PFC_RST_COUNT;
						nxt_level = !level_ff;
					end else begin
						nxt_cnt = cnt_ff + 16'h0001;
					end
				end
			end
			PFC_FT_SHOT_HIGH: begin
				if (gen_tick) begin
					if (cnt_ff == limit) begin
						nxt_cnt = PFC_RST_COUNT;
						nxt_level = 1'b0;
						nxt_state = PFC_FT_SHOT_LOW;
					end else begin
						nxt_cnt = cnt_ff + 16'h0001;
					end
				end
			end
			PFC_FT_SHOT_LOW: begin
				if (gen_tick) begin
					if (cnt_ff == limit) begin
						nxt_cnt = PFC_RST_COUNT;
						nxt_state = PFC_FT_IDLE;
					end else begin
						nxt_cnt = cnt_ff + 16'h0001;
					end
				end
			end
			default: begin
				nxt_state = PFC_FT_IDLE;
			end
		endcase
		if (ext_mode) begin
			nxt_trigger = general_pin_in[ft_ctl_ff.source_mode[1:0]];
		end else if (ft_ctl_ff.source_mode == PFC_MODE_BC0
				|| ft_ctl_ff.source_mode == PFC_MODE_BC1
				|| ft_ctl_ff.source_mode == PFC_MODE_REF) begin
			nxt_trigger = level_ff;
		end else begin
			nxt_trigger = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_ff <= PFC_FT_IDLE;
			cnt_ff <= PFC_RST_COUNT;
			level_ff <= 1'b0;
			frame_trigger_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			level_ff <= nxt_level;
			frame_trigger_ff <= nxt_trigger;
		end
	end

	// Pin three output mux
	logic nxt_pin_out;
	logic [1:0] en_lock;
	logic [1:0] en_pass;
	logic [3:0] remote;
	logic port_idx;

	always_comb begin
		en_lock = port_status.lock & port_status.enabled;
		en_pass = port_status.pass | ~port_status.enabled;
		port_idx = (pin_ctl_ff.source_select == PFC_SRC_PORT1);
		remote = port_idx ? port_status.remote_pins_1 : port_status.remote_pins_0;
		nxt_pin_out = 1'b0;
		if (pin_ctl_ff.source_select == PFC_SRC_PORT0
				|| pin_ctl_ff.source_select == PFC_SRC_PORT1) begin
			if (pin_ctl_ff.signal_select[2] == 1'b0) begin
				nxt_pin_out = remote[pin_ctl_ff.signal_select[1:0]];
			end else if (pin_ctl_ff.signal_select == PFC_SEL_LOCK) begin
				nxt_pin_out = port_status.lock[port_idx];
			end else if (pin_ctl_ff.signal_select == PFC_SEL_PASS) begin
				nxt_pin_out = port_status.pass[port_idx];
			end
		end else if (pin_ctl_ff.source_select == PFC_SRC_STATUS) begin
			if (pin_ctl_ff.signal_select == PFC_SEL_LOCAL) begin
				nxt_pin_out = pin_ctl_ff.local_value;
			end else if (pin_ctl_ff.signal_select == PFC_SEL_OR_LOCK) begin
				nxt_pin_out = |en_lock;
			end else if (pin_ctl_ff.signal_select == PFC_SEL_AND_LOCK) begin
				nxt_pin_out = (en_lock == port_status.enabled)
					&& (|port_status.enabled);
			end else if (pin_ctl_ff.signal_select == PFC_SEL_AND_PASS) begin
				nxt_pin_out = (&en_pass) && (|port_status.enabled);
			end else if (pin_ctl_ff.signal_select == PFC_SEL_TRIGGER) begin
				nxt_pin_out = frame_trigger_ff;
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			general_pin_three_out_ff <= 1'b0;
			general_pin_three_oe_ff <= 1'b0;
		end else begin
			general_pin_three_out_ff <= nxt_pin_out;
			general_pin_three_oe_ff <= pin_ctl_ff.drive_enable;
		end
	end

	// Checks
	sequence s_shot_start;
		(state_ff == PFC_FT_IDLE) && shot_req;
	endsequence
	sequence s_shot_high;
		(state_ff == PFC_FT_SHOT_HIGH) && level_ff;
	endsequence

	a_shot_starts: assert property (@(posedge clock) disable iff (reset)
		s_shot_start |=> s_shot_high)
		else $error("one-shot request did not start a pulse");
	a_shot_no_retrigger: assert property (@(posedge clock) disable iff (reset)
		(state_ff == PFC_FT_SHOT_HIGH) && shot_req && (cnt_ff != limit)
		|=> (state_ff == PFC_FT_SHOT_HIGH) && (cnt_ff == $past(cnt_ff + {15'h0000, gen_tick})))
		else $error("one-shot restarted during a pulse");
	a_shot_reads_zero: assert property (@(posedge clock) disable iff (reset)
		reg_read && (reg_addr == PFC_OFS_FT_CTL) |=> !reg_rdata_ff[PFC_BIT_ONE_SHOT])
		else $error("one-shot bit read back as one");
	a_pin_enable: assert property (@(posedge clock) disable iff (reset)
		reg_write && (reg_addr == PFC_OFS_PIN3_CTL) |=> ##1
		(general_pin_three_oe_ff == $past(reg_wdata[0], 2)))
		else $error("pin enable does not follow written bit");
	a_local_value: assert property (@(posedge clock) disable iff (reset)
		(pin_ctl_ff.source_select == PFC_SRC_STATUS) && (pin_ctl_ff.signal_select == PFC_SEL_LOCAL)
		|=> general_pin_three_out_ff == $past(pin_ctl_ff.local_value))
		else $error("pin does not show local value");
	a_or_lock: assert property (@(posedge clock) disable iff (reset)
		(pin_ctl_ff.source_select == PFC_SRC_STATUS) && (pin_ctl_ff.signal_select == PFC_SEL_OR_LOCK)
		|=> general_pin_three_out_ff == $past(|(port_status.lock & port_status.enabled)))
		else $error("pin does not show OR of lock");
	a_reserved_low: assert property (@(posedge clock) disable iff (reset)
		(pin_ctl_ff.source_select[1]) |=> !general_pin_three_out_ff)
		else $error("reserved source drives high");
	a_ext_trigger: assert property (@(posedge clock) disable iff (reset)
		ext_mode |=> frame_trigger_ff == $past(general_pin_in[ft_ctl_ff.source_mode[1:0]]))
		else $error("external trigger not forwarded");
	a_gen_idle: assert property (@(posedge clock) disable iff (reset)
		(state_ff == PFC_FT_IDLE) && !ft_ctl_ff.continuous_enable && !shot_req
		|=> (state_ff == PFC_FT_IDLE))
		else $error("generator left idle while disabled");
	a_phase_flip: assert property (@(posedge clock) disable iff (reset)
		(state_ff == PFC_FT_RUN) && ft_ctl_ff.continuous_enable && gen_tick && (cnt_ff == limit)
		|=> (level_ff != $past(level_ff)) && (cnt_ff == PFC_RST_COUNT))
		else $error("phase did not end after count plus one ticks");
endmodule

// ---- bench/pfc_pin_sampler.sv ----
// Model of the external logic sampling pin three
`timescale 1ns/1ps
module pfc_pin_sampler (
	// Clock
	input wire logic clock,
	// Pin three from the device
	input wire logic pin_out,
	input wire logic pin_oe,
	// Sampled wire level
	output logic level_ff
);
	logic flip_ff = 1'b0;
	logic wire_level;
	// Undriven wire shows a changing pattern
	assign wire_level = pin_oe ? pin_out : ~flip_ff;
	always_ff @(posedge clock) begin
		flip_ff <= ~flip_ff;
		level_ff <= wire_level;
	end
endmodule

// ---- bench/test_pin_output_mux_and_frame_trigger_ctl.sv ----
// Self-checking bench for pin three selection and frame trigger control
`timescale 1ns/1ps
module test_pin_output_mux_and_frame_trigger_ctl;
	import pfc_pkg::*;
	logic clock, reset, reg_write, reg_read, ref_tick, pin_out, pin_oe, ft, level;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, ctl;
	logic [1:0] bc_tick;
	logic [3:0] gpin;
	logic [7:0] addrs[6] = '{8'h13, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C};
	logic [3:0] rsvd[6] = '{4'h2, 4'h3, 4'hC, 4'hD, 4'hE, 4'hF};
	logic [3:0] gen[3] = '{4'h0, 4'h1, 4'h4};
	pfc_port_status_s st;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	pfc_pin_trigger pfc_pin_trigger_inst (.clock(clock), .reset(reset), .reg_addr(reg_addr),
		.reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
		.reg_rdata_ff(reg_rdata), .port_status(st), .bc_frame_tick(bc_tick),
		.ref_tick(ref_tick), .general_pin_in(gpin), .general_pin_three_out_ff(pin_out),
		.general_pin_three_oe_ff(pin_oe), .frame_trigger_ff(ft));
	pfc_pin_sampler pfc_pin_sampler_inst (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
		.level_ff(level));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge clock);
		reg_write = 1'b0;
		@(negedge clock);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge clock);
		reg_read = 1'b0;
		check("rdata", reg_rdata, exp);
		@(negedge clock);
	endtask
	task automatic run_len(input logic lvl, output int len);
		len = 0;
		for (int i = 0; i < 60 && ft !== lvl; i++) @(negedge clock);
		while (ft === lvl && len < 60) begin
			len++;
			@(negedge clock);
		end
	endtask
	function automatic logic exp_pin(logic [7:0] c, pfc_port_status_s s, logic trig);
		logic [3:0] rp;
		rp = c[2] ? s.remote_pins_1 : s.remote_pins_0;
		if (c[4:2] == 3'h4) begin
			case (c[7:5])
				3'h0: return c[1];
				3'h1: return |(s.lock & s.enabled);
				3'h2: return s.enabled != 2'h0 && &(s.lock | ~s.enabled);
				3'h3: return s.enabled != 2'h0 && &(s.pass | ~s.enabled);
				3'h4: return trig;
				default: return 1'b0;
			endcase
		end
		if (c[4:3] != 2'h0) return 1'b0;
		if (!c[7]) return rp[c[6:5]];
		return c[7:5] == 3'h4 ? s.lock[c[2]] : c[7:5] == 3'h5 ? s.pass[c[2]] : 1'b0;
	endfunction
	initial begin
		reset = 1'b1;
		{reg_write, reg_read, ref_tick, reg_addr, reg_wdata, bc_tick, gpin} = '0;
		st = '0;
		void'($urandom(32'hC5BF3AFA));
		repeat (16) @(negedge clock);
		reset = 1'b0;
		check("oe", pin_oe, 8'h00);
		check("trigger", ft, 8'h00);
		foreach (addrs[i]) rdchk(addrs[i], 8'h00);
		wr(8'h14, 8'hA5);
		rdchk(8'h14, 8'h00);
		// Pin mux against the model, trigger taken from pin zero
		wr(8'h18, 8'h80);
		for (int i = 0; i < 60; i++) begin
			ctl = 8'($urandom);
			if ($urandom % 2) ctl[4:2] = 3'h4;
			st = pfc_port_status_s'(14'($urandom));
			gpin = 4'($urandom);
			wr(8'h13, ctl);
			repeat (4) @(negedge clock);
			check("oe", pin_oe, ctl[0]);
			check("pin", pin_out, exp_pin(ctl, st, gpin[0]));
			if (ctl[0]) check("wire", level, exp_pin(ctl, st, gpin[0]));
			rdchk(8'h13, ctl);
		end
		for (int m = 8; m < 12; m++) begin
			wr(8'h18, 8'(m << 4));
			repeat (3) begin
				gpin = 4'($urandom);
				repeat (2) @(negedge clock);
				check("ext", ft, gpin[m - 8]);
			end
		end
		foreach (rsvd[i]) begin
			wr(8'h18, {rsvd[i], 4'h0});
			gpin = 4'hF;
			ref_tick = 1'b1;
			bc_tick = 2'h3;
			repeat (4) @(negedge clock);
			check("rsvd", ft, 8'h00);
		end
		// Continuous generation, high three ticks, low two ticks
		wr(8'h1A, 8'h02);
		wr(8'h1C, 8'h01);
		foreach (gen[i]) begin
			bc_tick = {gen[i] == 4'h1, gen[i] == 4'h0};
			ref_tick = gen[i] == 4'h4;
			wr(8'h18, {gen[i], 4'h5});
			repeat (2) @(negedge clock);
			check("init", ft, 8'h01);
			run_len(1'b1, n);
			run_len(1'b0, n);
			check("low", 8'(n), 8'h02);
			run_len(1'b1, n);
			check("high", 8'(n), 8'h03);
			wr(8'h18, {gen[i], 4'h0});
			repeat (8) @(negedge clock);
			check("off", ft, 8'h00);
		end
		// One-shot with a second request during the pulse
		wr(8'h18, 8'h48);
		n = 0;
		fork
			wr(8'h18, 8'h48);
			repeat (14) begin
				n += ft;
				@(negedge clock);
			end
		join
		check("shot", 8'(n), 8'h03);
		rdchk(8'h18, 8'h40);
		close_out();
	end
endmodule
